//--- gpio_result_pkg.sv
// Constants shared by the pin status and measurement result register bank.
package gpio_result_pkg;

    // Width of the APB byte address.
    localparam int ADDR_W = 12;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] PIN_STATUS_IDX = 8'h25;
    localparam logic [7:0] RESULT_FIRST_IDX = 8'h26;
    localparam logic [7:0] BATTERY_IDX = 8'h26;
    localparam logic [7:0] ANALOG_IN_8_IDX = 8'h27;
    localparam logic [7:0] REMOTE_TEMP_ONE_IDX = 8'h28;
    localparam logic [7:0] SHARED_TEMP_AIN_IDX = 8'h29;
    localparam logic [7:0] STANDBY_3V3_IDX = 8'h2a;
    localparam logic [7:0] MAIN_3V3_IDX = 8'h2b;
    localparam logic [7:0] RAIL_5V_IDX = 8'h2c;
    localparam logic [7:0] CORE_RAIL_IDX = 8'h2d;
    localparam logic [7:0] RAIL_POS12_IDX = 8'h2e;
    localparam logic [7:0] RAIL_NEG12_IDX = 8'h2f;
    localparam logic [7:0] ANALOG_IN_0_IDX = 8'h30;
    localparam logic [7:0] ANALOG_IN_1_IDX = 8'h31;
    localparam logic [7:0] RESULT_LAST_IDX = 8'h32;
    localparam int RESULT_COUNT = 13;

    // Configuration and limit registers placed in free index space.
    localparam logic [7:0] PIN_CFG3_IDX = 8'h60;
    localparam logic [7:0] PIN_CFG4_IDX = 8'h61;
    localparam logic [7:0] BAT_HIGH_IDX = 8'h62;
    localparam logic [7:0] BAT_LOW_IDX = 8'h63;
    localparam logic [7:0] ANALOG_IN_8_HIGH_IDX = 8'h64;
    localparam logic [7:0] ANALOG_IN_8_LOW_IDX = 8'h65;
    localparam logic [7:0] LIMIT_STATUS_IDX = 8'h66;
    localparam logic [7:0] SHARED_MODE_IDX = 8'h67;

    // Values after reset.
    localparam logic [7:0] PIN_STATUS_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] PIN_CFG_RESET = 8'h00;
    localparam logic [7:0] HIGH_LIMIT_RESET = 8'hff;
    localparam logic [7:0] LOW_LIMIT_RESET = 8'h00;

    // Field positions.
    localparam int LIMIT_BAT_BIT = 0;
    localparam int LIMIT_ANALOG_IN_8_BIT = 1;
    localparam int SHARED_MODE_BIT = 0;
    localparam int PINS_PER_CFG = 4;

    // Channel codes presented by the conversion engine.
    localparam logic [3:0] CH_BATTERY = 4'h0;
    localparam logic [3:0] CH_ANALOG_IN_8 = 4'h1;
    localparam logic [3:0] CH_REMOTE_TEMP_TWO = 4'h3;
    localparam logic [3:0] CH_LAST_PLAIN = 4'hc;
    localparam logic [3:0] CH_ANALOG_IN_9 = 4'hd;

    // Result slots, counted from the first result index.
    localparam logic [3:0] SLOT_BATTERY = 4'h0;
    localparam logic [3:0] SLOT_ANALOG_IN_8 = 4'h1;
    localparam logic [3:0] SLOT_SHARED = 4'h3;
    localparam logic [3:0] SLOT_RAIL_NEG12 = 4'h9;

endpackage

//--- gpio_pin_cell.sv
// One general-purpose pin with its status bit, direction and polarity.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_cell (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin_in,
    input wire logic is_output,
    input wire logic active_high,
    input wire logic wr_en,
    input wire logic wr_data,
    output logic status,
    output logic pin_out,
    output logic pin_oe
);

    logic status_r; // Status bit as software sees it.
    logic status_nxt; // Next status bit.
    logic pin_out_r; // Registered pin drive level.
    logic pin_oe_r; // Registered pin output enable.

    // An input tracks its asserted state; an output takes software writes only.
    always_comb begin
        status_nxt = status_r;
        if (!is_output) begin
            status_nxt = (pin_in == active_high);
        end else if (wr_en) begin
            status_nxt = wr_data;
        end
    end

    // Status register, cleared at reset.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Pin drive: asserted status gives the active level chosen by polarity.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            pin_out_r <= ~(status_nxt ^ active_high);
            pin_oe_r <= is_output;
        end
    end

    assign status = status_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;

    // An input pin's status follows the pin's asserted state one edge later.
    property p_input_track;
        @(posedge clk) disable iff (!rst_b)
        !is_output |=> status_r == $past(pin_in == active_high);
    endproperty
    a_input_track: assert property (p_input_track) else $error("input status wrong");

    // An input pin ignores writes.
    property p_input_ro;
        @(posedge clk) disable iff (!rst_b)
        (!is_output && wr_en && (wr_data != (pin_in == active_high))) |=> status_r != $past(wr_data);
    endproperty
    a_input_ro: assert property (p_input_ro) else $error("input status took a write");

    // A write to an output pin drives the matching level next edge.
    property p_output_drive;
        @(posedge clk) disable iff (!rst_b)
        (is_output && wr_en) |=> pin_oe_r && pin_out_r == ($past(wr_data) ~^ $past(active_high));
    endproperty
    a_output_drive: assert property (p_output_drive) else $error("pin drive level wrong");

endmodule
`default_nettype wire

//--- gpio_status_and_result_regs.sv
// APB register bank holding the upper pin status byte and the measurement results.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
module gpio_status_and_result_regs #(
    parameter int PIN_COUNT = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpio_result_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    input wire logic conv_valid,
    input wire logic [3:0] conv_channel,
    input wire logic [7:0] conv_data
);

    // Bus-side registers.
    logic [31:0] prdata_r; // Read data held for the access phase.
    logic pready_r; // Ready, high in the access phase only.
    logic pslverr_r; // Error answer for unmapped addresses.

    // Configuration registers.
    logic [7:0] pin_cfg3_r; // Direction in even bits, polarity in odd bits, pins 8..11.
    logic [7:0] pin_cfg4_r; // Same layout for pins 12..15.
    logic [7:0] bat_high_r; // Battery high limit.
    logic [7:0] bat_low_r; // Battery low limit.
    logic [7:0] analog_in_8_high_r; // Analog input 8 high limit.
    logic [7:0] analog_in_8_low_r; // Analog input 8 low limit.
    logic shared_mode_r; // One selects analog input 9 on the shared pins.
    logic [1:0] limit_status_r; // Out-of-limit flags from the last conversion.

    // Result memory, one byte per channel slot.
    logic [7:0] result_r [0:gpio_result_pkg::RESULT_COUNT-1];

    // Decode helpers.
    logic [7:0] bus_idx; // Register index taken from the address.
    logic addr_ok; // Address is word aligned and inside the index space.
    logic setup_phase; // First cycle of an APB transfer.
    logic wr_fire; // Write commits at this edge.
    logic [31:0] rd_data_nxt; // Read data for the current address.
    logic rd_err_nxt; // Error answer for the current address.
    logic [7:0] result_slot; // Index minus first result index.
    logic [PIN_COUNT-1:0] pin_status; // Status bits from the pin cells.
    logic [PIN_COUNT-1:0] pin_dir; // Direction per pin, one is output.
    logic [PIN_COUNT-1:0] pin_pol; // Polarity per pin, one is active high.
    logic [15:0] pin_cfg_both; // Configuration four above configuration three.
    logic pin_wr_en; // Write strobe for the pin status register.

    // Conversion helpers.
    logic conv_take; // The conversion result is stored.
    logic [3:0] conv_slot; // Slot that receives the result.

    // Address split: word index and checks on the unused bits.
    assign bus_idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[gpio_result_pkg::ADDR_W-1:10] == 2'b00);
    assign setup_phase = psel && !penable;
    assign wr_fire = psel && penable && pready_r && pwrite && addr_ok;
    assign result_slot = bus_idx - gpio_result_pkg::RESULT_FIRST_IDX;
    assign pin_wr_en = wr_fire && (bus_idx == gpio_result_pkg::PIN_STATUS_IDX);

    // Read decode; unmapped addresses answer with an error and zero data.
    always_comb begin
        rd_data_nxt = 32'h0000_0000;
        rd_err_nxt = 1'b0;
        if (!addr_ok) begin
            rd_err_nxt = 1'b1;
        end else if (bus_idx == gpio_result_pkg::PIN_STATUS_IDX) begin
            rd_data_nxt[PIN_COUNT-1:0] = pin_status;
        end else if ((bus_idx >= gpio_result_pkg::RESULT_FIRST_IDX) &&
                     (bus_idx <= gpio_result_pkg::RESULT_LAST_IDX)) begin
            rd_data_nxt[7:0] = result_r[result_slot[3:0]];
        end else if (bus_idx == gpio_result_pkg::PIN_CFG3_IDX) begin
            rd_data_nxt[7:0] = pin_cfg3_r;
        end else if (bus_idx == gpio_result_pkg::PIN_CFG4_IDX) begin
            rd_data_nxt[7:0] = pin_cfg4_r;
        end else if (bus_idx == gpio_result_pkg::BAT_HIGH_IDX) begin
            rd_data_nxt[7:0] = bat_high_r;
        end else if (bus_idx == gpio_result_pkg::BAT_LOW_IDX) begin
            rd_data_nxt[7:0] = bat_low_r;
        end else if (bus_idx == gpio_result_pkg::ANALOG_IN_8_HIGH_IDX) begin
            rd_data_nxt[7:0] = analog_in_8_high_r;
        end else if (bus_idx == gpio_result_pkg::ANALOG_IN_8_LOW_IDX) begin
            rd_data_nxt[7:0] = analog_in_8_low_r;
        end else if (bus_idx == gpio_result_pkg::LIMIT_STATUS_IDX) begin
            rd_data_nxt[1:0] = limit_status_r;
        end else if (bus_idx == gpio_result_pkg::SHARED_MODE_IDX) begin
            rd_data_nxt[gpio_result_pkg::SHARED_MODE_BIT] = shared_mode_r;
        end else begin
            rd_err_nxt = 1'b1;
        end
    end

    // APB answer: one wait-free access phase after every setup cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup_phase && !pready_r;
            if (setup_phase) begin
                pslverr_r <= rd_err_nxt;
                prdata_r <= pwrite ? 32'h0000_0000 : rd_data_nxt;
            end else if (pready_r) begin
                pslverr_r <= 1'b0;
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // Pin configuration registers, written by software.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_cfg3_r <= gpio_result_pkg::PIN_CFG_RESET;
            pin_cfg4_r <= gpio_result_pkg::PIN_CFG_RESET;
            shared_mode_r <= 1'b0;
        end else if (wr_fire) begin
            if (bus_idx == gpio_result_pkg::PIN_CFG3_IDX) begin
                pin_cfg3_r <= pwdata[7:0];
            end else if (bus_idx == gpio_result_pkg::PIN_CFG4_IDX) begin
                pin_cfg4_r <= pwdata[7:0];
            end else if (bus_idx == gpio_result_pkg::SHARED_MODE_IDX) begin
                shared_mode_r <= pwdata[gpio_result_pkg::SHARED_MODE_BIT];
            end
        end
    end

    // Limit registers for the two compared channels.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bat_high_r <= gpio_result_pkg::HIGH_LIMIT_RESET;
            bat_low_r <= gpio_result_pkg::LOW_LIMIT_RESET;
            analog_in_8_high_r <= gpio_result_pkg::HIGH_LIMIT_RESET;
            analog_in_8_low_r <= gpio_result_pkg::LOW_LIMIT_RESET;
        end else if (wr_fire) begin
            if (bus_idx == gpio_result_pkg::BAT_HIGH_IDX) begin
                bat_high_r <= pwdata[7:0];
            end else if (bus_idx == gpio_result_pkg::BAT_LOW_IDX) begin
                bat_low_r <= pwdata[7:0];
            end else if (bus_idx == gpio_result_pkg::ANALOG_IN_8_HIGH_IDX) begin
                analog_in_8_high_r <= pwdata[7:0];
            end else if (bus_idx == gpio_result_pkg::ANALOG_IN_8_LOW_IDX) begin
                analog_in_8_low_r <= pwdata[7:0];
            end
        end
    end

    // Channel to slot; the shared slot takes only the configured function.
    always_comb begin
        conv_slot = conv_channel;
        conv_take = 1'b0;
        if (conv_valid) begin
            if (conv_channel == gpio_result_pkg::CH_ANALOG_IN_9) begin
                conv_slot = gpio_result_pkg::SLOT_SHARED;
                conv_take = shared_mode_r;
            end else if (conv_channel == gpio_result_pkg::CH_REMOTE_TEMP_TWO) begin
                conv_take = !shared_mode_r;
            end else if (conv_channel <= gpio_result_pkg::CH_LAST_PLAIN) begin
                conv_take = 1'b1;
            end
        end
    end

    // Results are written whole in one edge, so a read never sees a partial byte.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < gpio_result_pkg::RESULT_COUNT; i++) begin
                result_r[i] <= gpio_result_pkg::RESULT_RESET;
            end
        end else if (conv_take) begin
            result_r[conv_slot] <= conv_data;
        end
    end

    // Out-of-limit flags reflect the most recent conversion of each channel.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            limit_status_r <= 2'b00;
        end else if (conv_valid) begin
            if (conv_channel == gpio_result_pkg::CH_BATTERY) begin
                limit_status_r[gpio_result_pkg::LIMIT_BAT_BIT] <=
                    (conv_data > bat_high_r) || (conv_data < bat_low_r);
            end else if (conv_channel == gpio_result_pkg::CH_ANALOG_IN_8) begin
                limit_status_r[gpio_result_pkg::LIMIT_ANALOG_IN_8_BIT] <=
                    (conv_data > analog_in_8_high_r) || (conv_data < analog_in_8_low_r);
            end
        end
    end

    // Both configuration bytes side by side, so pin n uses bits 2n and 2n+1 with no range hazard.
    assign pin_cfg_both = {pin_cfg4_r, pin_cfg3_r};

    // Per-pin direction and polarity from the two configuration registers.
    always_comb begin
        for (int p = 0; p < PIN_COUNT; p++) begin
            pin_dir[p] = pin_cfg_both[2*p];
            pin_pol[p] = pin_cfg_both[2*p+1];
        end
    end

    // One cell per pin; status bit n belongs to pin 8 plus n.
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        gpio_pin_cell u_cell (
            .clk(clk),
            .rst_b(rst_b),
            .pin_in(pin_in[g]),
            .is_output(pin_dir[g]),
            .active_high(pin_pol[g]),
            .wr_en(pin_wr_en),
            .wr_data(pwdata[g]),
            .status(pin_status[g]),
            .pin_out(pin_out[g]),
            .pin_oe(pin_oe[g])
        );
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Helper views of single result slots for the checks below.
    logic [7:0] bat_result_view;
    logic [7:0] shared_result_view;
    logic [7:0] neg12_result_view;
    assign bat_result_view = result_r[gpio_result_pkg::SLOT_BATTERY];
    assign shared_result_view = result_r[gpio_result_pkg::SLOT_SHARED];
    assign neg12_result_view = result_r[gpio_result_pkg::SLOT_RAIL_NEG12];

    // Every setup cycle is answered in the next cycle, and only for one cycle.
    property p_ready_once;
        @(posedge clk) disable iff (!rst_b)
        setup_phase |=> pready_r ##1 !pready_r;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready timing wrong");

    // A battery conversion lands whole in its result register.
    property p_bat_update;
        @(posedge clk) disable iff (!rst_b)
        (conv_valid && conv_channel == gpio_result_pkg::CH_BATTERY)
            |=> bat_result_view == $past(conv_data);
    endproperty
    a_bat_update: assert property (p_bat_update) else $error("battery result not stored");

    // Bus writes never change a result register.
    property p_result_ro;
        @(posedge clk) disable iff (!rst_b)
        (!conv_valid && wr_fire) |=> $stable(bat_result_view) && $stable(neg12_result_view);
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result changed by a write");

    // The shared slot ignores the function that is not selected.
    property p_shared_select;
        @(posedge clk) disable iff (!rst_b)
        (conv_valid && shared_mode_r && conv_channel == gpio_result_pkg::CH_REMOTE_TEMP_TWO)
            |=> $stable(shared_result_view);
    endproperty
    a_shared_select: assert property (p_shared_select) else $error("shared slot wrong");

    // A read of the -12 V result returns the slot's value.
    property p_read_neg12;
        @(posedge clk) disable iff (!rst_b)
        (setup_phase && !pwrite && addr_ok && bus_idx == gpio_result_pkg::RAIL_NEG12_IDX)
            |=> prdata_r == {24'h00_0000, $past(neg12_result_view)} && !pslverr_r;
    endproperty
    a_read_neg12: assert property (p_read_neg12) else $error("read of -12 V result wrong");

    // Input 8 limit flag follows the comparison of the last conversion.
    property p_analog_in_8_limit;
        @(posedge clk) disable iff (!rst_b)
        (conv_valid && conv_channel == gpio_result_pkg::CH_ANALOG_IN_8)
            |=> limit_status_r[gpio_result_pkg::LIMIT_ANALOG_IN_8_BIT] ==
                (($past(conv_data) > $past(analog_in_8_high_r)) ||
                 ($past(conv_data) < $past(analog_in_8_low_r)));
    endproperty
    a_analog_in_8_limit: assert property (p_analog_in_8_limit) else $error("limit flag wrong");

    // Pin status read returns the pin cells' bits in order.
    property p_status_read;
        @(posedge clk) disable iff (!rst_b)
        (setup_phase && !pwrite && addr_ok && bus_idx == gpio_result_pkg::PIN_STATUS_IDX)
            |=> prdata_r[PIN_COUNT-1:0] == $past(pin_status);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // A write to an input pin's status bit leaves that bit at the pin's state.
    property p_pin8_input;
        @(posedge clk) disable iff (!rst_b)
        (pin_wr_en && !pin_dir[0]) |=> pin_status[0] == ($past(pin_in[0]) == $past(pin_pol[0]));
    endproperty
    a_pin8_input: assert property (p_pin8_input) else $error("input bit accepted write");

    // The selected analog input 9 result lands in the shared slot.
    property p_shared_analog_in_9;
        @(posedge clk) disable iff (!rst_b)
        (conv_valid && shared_mode_r && conv_channel == gpio_result_pkg::CH_ANALOG_IN_9)
            |=> shared_result_view == $past(conv_data);
    endproperty
    a_shared_analog_in_9: assert property (p_shared_analog_in_9) else $error("input 9 lost");

    // Battery limit flag follows the comparison of the last conversion.
    property p_bat_limit;
        @(posedge clk) disable iff (!rst_b)
        (conv_valid && conv_channel == gpio_result_pkg::CH_BATTERY)
            |=> limit_status_r[gpio_result_pkg::LIMIT_BAT_BIT] ==
                (($past(conv_data) > $past(bat_high_r)) ||
                 ($past(conv_data) < $past(bat_low_r)));
    endproperty
    a_bat_limit: assert property (p_bat_limit) else $error("battery flag wrong");

    // A misaligned or out-of-range address is answered with an error and zero data.
    property p_bad_addr_err;
        @(posedge clk) disable iff (!rst_b)
        (setup_phase && !addr_ok) |=> pready_r && pslverr_r && prdata_r == 32'h0000_0000;
    endproperty
    a_bad_addr_err: assert property (p_bad_addr_err) else $error("bad address not refused");

    // Read data and error stand only while ready is high, so stale values never leak.
    property p_idle_quiet;
        @(posedge clk) disable iff (!rst_b)
        !pready_r |-> prdata_r == 32'h0000_0000 && !pslverr_r;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("answer outside access phase");

endmodule
`default_nettype wire

//--- conv_engine_model.sv
// Conversion engine model that hands finished results to the register bank.
`timescale 1ns/1ps
`default_nettype none
module conv_engine_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [3:0] ch,
    input wire logic [7:0] data,
    output logic conv_valid,
    output logic [3:0] conv_channel,
    output logic [7:0] conv_data
);
    // One pulse per request; between pulses the data toggles so stale values never look valid.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_valid <= 1'b0;
            conv_channel <= 4'h0;
            conv_data <= 8'h00;
        end else if (start) begin
            conv_valid <= 1'b1;
            conv_channel <= ch;
            conv_data <= data;
        end else begin
            conv_valid <= 1'b0;
            conv_data <= ~conv_data;
        end
    end
endmodule
`default_nettype wire

//--- gpio_status_and_result_regs_bench.sv
// Self-checking bench for the pin status and measurement result register bank.
`timescale 1ns/1ps
`default_nettype none
module gpio_status_and_result_regs_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [7:0] pin_in = 8'hff;
    logic [7:0] pin_out, pin_oe;
    logic start = 1'b0;
    logic [3:0] ch = 4'h0;
    logic [7:0] data = 8'h00;
    logic conv_valid;
    logic [3:0] conv_channel;
    logic [7:0] conv_data;
    logic [9:0] notes[$]; // Expected answers: check-data flag, error, data.
    logic [9:0] n;
    logic [7:0] v;
    logic [7:0] res0, res3; // Results kept for later comparison.
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'hddd8_0858;

    gpio_status_and_result_regs i_gpio_status_and_result_regs (.clk(clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .conv_valid(conv_valid),
        .conv_channel(conv_channel), .conv_data(conv_data));
    conv_engine_model i_conv_engine_model (.clk(clk), .rst_b(rst_b), .start(start), .ch(ch),
        .data(data), .conv_valid(conv_valid), .conv_channel(conv_channel),
        .conv_data(conv_data));

    // Free-running 100 ns clock.
    initial forever #50 clk = ~clk;

    // Compares one value and counts the outcome.
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task complete_run;
        $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One APB transfer; the note is queued for the watching process.
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] wd, input logic [9:0] nt);
        notes.push_back(nt);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register read and write by index.
    task rd(input logic [7:0] idx, input logic [7:0] e, input logic err);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00, {1'b1, err, e});
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d, {2'b00, 8'h00});
    endtask

    // Asks the engine model for one conversion and waits until it is presented.
    task conv(input logic [3:0] c, input logic [7:0] d);
        @(posedge clk);
        start <= 1'b1;
        ch <= c;
        data <= d;
        @(posedge clk);
        start <= 1'b0;
        do @(posedge clk); while (conv_valid !== 1'b1);
    endtask

    // Watches completed transfers and compares them with the oldest note; also the timeout.
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            error_cnt++;
            complete_run();
        end else if (psel && penable && pready === 1'b1) begin
            n = notes.pop_front();
            check("pslverr", {7'h00, pslverr}, {7'h00, n[8]});
            check("prdata_hi", {7'h00, |prdata[31:8]}, 8'h00);
            if (n[9]) check("prdata", prdata[7:0], n[7:0]);
        end
    end

    // Main sequence.
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values of the pin status and result registers and the pin enables.
        rd(gpio_result_pkg::PIN_STATUS_IDX, 8'h00, 1'b0);
        for (int i = 0; i < 13; i++) rd(8'(8'h26 + i), 8'h00, 1'b0);
        check("pin_oe", pin_oe, 8'h00);
        // Each channel lands in its own slot, read right after the conversion.
        for (int i = 0; i < 13; i++) begin
            v = 8'($random(seed));
            if (i == 0) res0 = v;
            if (i == 3) res3 = v;
            conv(4'(i), v);
            rd(8'(8'h26 + i), v, 1'b0);
        end
        // Results ignore writes; shared slot follows the mode bit.
        wr(8'h26, ~res0);
        rd(8'h26, res0, 1'b0);
        wr(gpio_result_pkg::SHARED_MODE_IDX, 8'h01);
        conv(4'h3, ~res3);
        rd(8'h29, res3, 1'b0);
        conv(4'hd, 8'h5c);
        rd(8'h29, 8'h5c, 1'b0);
        // Unmapped index and misaligned address are refused.
        rd(8'h50, 8'h00, 1'b1);
        apb(1'b0, 12'h099, 8'h00, {2'b11, 8'h00});
        // Limit flags are recomputed at every conversion of their own channel.
        wr(gpio_result_pkg::BAT_HIGH_IDX, 8'h80);
        conv(4'h0, 8'h90);
        rd(gpio_result_pkg::LIMIT_STATUS_IDX, 8'h01, 1'b0);
        conv(4'h0, 8'h10);
        wr(gpio_result_pkg::ANALOG_IN_8_LOW_IDX, 8'h20);
        conv(4'h1, 8'h10);
        rd(gpio_result_pkg::LIMIT_STATUS_IDX, 8'h02, 1'b0);
        // Input pins, active low first, then active high per group.
        v = 8'($random(seed));
        pin_in <= v;
        rd(gpio_result_pkg::PIN_STATUS_IDX, ~v, 1'b0);
        wr(gpio_result_pkg::PIN_CFG3_IDX, 8'haa);
        rd(gpio_result_pkg::PIN_STATUS_IDX, {~v[7:4], v[3:0]}, 1'b0);
        wr(gpio_result_pkg::PIN_CFG4_IDX, 8'haa);
        rd(gpio_result_pkg::PIN_STATUS_IDX, v, 1'b0);
        wr(gpio_result_pkg::PIN_STATUS_IDX, ~v);
        rd(gpio_result_pkg::PIN_STATUS_IDX, v, 1'b0);
        // Output pins: low group active high, high group active low.
        wr(gpio_result_pkg::PIN_CFG3_IDX, 8'hff);
        wr(gpio_result_pkg::PIN_CFG4_IDX, 8'h55);
        v = 8'($random(seed));
        wr(gpio_result_pkg::PIN_STATUS_IDX, v);
        rd(gpio_result_pkg::PIN_STATUS_IDX, v, 1'b0);
        repeat (2) @(posedge clk);
        check("pin_oe", pin_oe, 8'hff);
        check("pin_out", pin_out, {~v[7:4], v[3:0]});
        // A second reset in mid-run clears pins and results; pins idle high, deasserted.
        pin_in <= 8'hff;
        rst_b <= 1'b0;
        @(posedge clk);
        check("pin_oe", pin_oe, 8'h00);
        rst_b <= 1'b1;
        rd(8'h26, 8'h00, 1'b0);
        rd(gpio_result_pkg::PIN_STATUS_IDX, 8'h00, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
